// *** rtl/rbd_register_bus_datapath.sv ***
/*
  Processor datapath: active registers, input gating, ripple adder,
  shifter and shared register bus, paced by five time states.
  Assumes core memory control returns read data by the end of TS2 and
  takes the write pattern while memOut.write is high; APB master on sys_clk.
*/
`timescale 1ns/1ps
`include "rbd_defines.svh"

// Behaviour
// - Active registers load only from register bus
// - Sources, gating, adder, shifter, then bus
// - Gating merges enabled sources into operand pair
// - One adder per bit, carry ripples up
// - Shifter passes, shifts right or left
// - Load control enables only decoded destinations
// - Extension register fed only from work register
// - Carry out of msb on add complements link
// - Link set/clear alone; rotate inclusion selectable
// - Work register shift, rotate, increment, clear, complement, store, add, compare
// - Work register holds sum after add
// - Pointer holds next instruction address
// - Fetched word to opcode register, decoded
// - Timing starts memory cycle; read data buffered
// - Buffer contents written back each cycle
// - Console chain end starts running timing
// - I/O transfers buffered, synchronised to timing
// - Terminal out from work register; in via bus
// - Five time states, each ended by pulse
module rbd_register_bus_datapath (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Register bus
  input  wire rbd_pkg::rbd_apb_req_t apbReq,
  output      rbd_pkg::rbd_apb_rsp_t apbRsp,
  // Core memory control
  output      rbd_pkg::rbd_mem_t memOut,
  input  wire logic [11:0]       memRdData,
  // I/O bus and terminal
  input  wire logic [11:0]       ioIn,
  input  wire logic [7:0]        ttyRxData,
  output      logic [11:0]       ioOut,
  output      logic [7:0]        ttyTxData,
  output      logic              ttyTxStrobe
);
  import rbd_pkg::*;

  logic [11:0] ac;
  logic        link;
  logic [11:0] pc;
  logic [11:0] ma;
  logic [11:0] mb;
  logic [11:0] ir;
  logic [11:0] mq;
  logic [11:0] sw;
  logic [11:0] readBuf;
  logic [11:0] ioBuf;
  rbd_tstate_t tState;
  logic        run;
  logic        exec;
  logic        stopReq;
  logic [`RBD_CONSOLE_STEPS-1:0] conChain;
  logic [31:0] rdData;
  logic        rdErr;
  logic [19:0] ioS1;
  logic [19:0] ioS2;
  logic [19:0] ioS3;
  logic [19:0] ioStable;

  // Decoded control word for the current time state
  function automatic rbd_ctl_t decode(rbd_tstate_t ts, logic ex,
                                      logic [11:0] i, logic eq);
    rbd_ctl_t c;
    logic [2:0] op;
    c = '0;
    op = i[11:9];
    case (ts)
      TS1: begin
        if (!ex) begin
          c.enPc = 1'b1;
          c.ldMa = 1'b1;
        end
      end
      TS2: begin
        if (!ex) begin
          c.enPc = 1'b1;
          c.carryIn = 1'b1;
          c.ldPc = 1'b1;
        end
      end
      TS3: begin
        c.enRd = 1'b1;
        c.ldMb = 1'b1;
        c.ldIr = !ex;
      end
      TS4: begin
        if (!ex) begin
          if (op == `RBD_OP_JMP) begin
            c.enAddr = 1'b1;
            c.ldPc = 1'b1;
          end else if (op == `RBD_OP_IOT) begin
            c.enAc = 1'b1;
            c.enIo = i[1];
            c.ldAc = i[1];
          end else if (op == `RBD_OP_OPR) begin
            c.enAc = !i[7];
            c.ldAc = 1'b1;
            c.linkClr = i[6];
          end
        end else begin
          case (op)
            `RBD_OP_AND: begin
              c.enAnd = 1'b1;
              c.ldAc = 1'b1;
            end
            `RBD_OP_TAD: begin
              c.enAc = 1'b1;
              c.enMb = 1'b1;
              c.ldAc = 1'b1;
              c.linkCarry = 1'b1;
            end
            `RBD_OP_DCA: begin
              c.enAc = 1'b1;
              c.ldMb = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      TS5: begin
        if (!ex && op == `RBD_OP_OPR) begin
          c.enAc = !i[5];
          c.enAcN = i[5];
          c.carryIn = i[0];
          c.linkCmp = i[4];
          c.shift = i[3] ? SH_RIGHT : (i[2] ? SH_LEFT : SH_PASS);
          c.rotLink = i[1];
          c.ldAc = 1'b1;
        end else if (!ex && op <= `RBD_OP_DCA) begin
          c.enAddr = 1'b1;
          c.ldMa = 1'b1;
        end else if (!ex && op == `RBD_OP_MQL) begin
          c.mqFromAc = 1'b1;
          c.ldAc = 1'b1;
        end else if (ex && op == `RBD_OP_CMP && eq) begin
          c.enPc = 1'b1;
          c.carryIn = 1'b1;
          c.ldPc = 1'b1;
        end else if (ex && op == `RBD_OP_DCA) begin
          c.ldAc = 1'b1;
        end
      end
      default: begin
      end
    endcase
    return c;
  endfunction

  // Register bus decode
  wire apbSetup = apbReq.psel && !apbReq.penable;
  wire apbWr    = apbReq.psel && apbReq.penable && apbReq.pwrite;
  wire wrCtrl   = apbWr && apbReq.paddr == `RBD_A_CTRL;
  wire wrSwitch = apbWr && apbReq.paddr == `RBD_A_SWITCH;
  wire conLdPc  = wrCtrl && !run && apbReq.pwdata[`RBD_CTRL_LDNIP];
  wire conLdAc  = wrCtrl && !run && apbReq.pwdata[`RBD_CTRL_LDWRK];
  wire conStart = wrCtrl && !run && apbReq.pwdata[`RBD_CTRL_START];
  wire conStop  = wrCtrl && apbReq.pwdata[`RBD_CTRL_STOP];

  // Console deposits share the bus path; nothing bypasses it
  rbd_ctl_t runCtl;
  rbd_ctl_t conCtl;
  rbd_ctl_t ctl;
  assign runCtl = decode(tState, exec, ir, ac == mb);
  assign conCtl = '{enSw: 1'b1, ldPc: conLdPc, ldAc: conLdAc, shift: SH_PASS, default: 1'b0};
  assign ctl = run ? runCtl : conCtl;

  // Gating stage: OR-merge of enabled sources per operand; enAnd puts ac & mb on opA instead
  wire [11:0] ioBus = ioStable[11:0] | {4'h0, ioStable[19:12]};
  wire [11:0] opA =
    ctl.enAnd ? (ac & mb) :
    ((ctl.enAc  ? ac      : 12'h000) |
     (ctl.enAcN ? ~ac     : 12'h000) |
     (ctl.enPc  ? pc      : 12'h000) |
     (ctl.enRd  ? readBuf : 12'h000) |
     (ctl.enIo  ? ioBuf   : 12'h000) |
     (ctl.enSw  ? sw      : 12'h000));
  wire [11:0] opB = (ctl.enMb   ? mb              : 12'h000) |
                    (ctl.enAddr ? {5'h00, ir[6:0]} : 12'h000);

  // Ripple adder, one cell per bit
  logic [12:0] carry;
  logic [11:0] sum;
  assign carry[0] = ctl.carryIn;
  genvar g;
  generate
    for (g = 0; g < 12; g = g + 1) begin : gAdd
      assign sum[g] = opA[g] ^ opB[g] ^ carry[g];
      assign carry[g+1] = (opA[g] & opB[g]) | (carry[g] & (opA[g] ^ opB[g]));
    end
  endgenerate

  // Shifter; rotate fill is the link or the word's own end bit
  wire fillR = ctl.rotLink ? link : sum[0];
  wire fillL = ctl.rotLink ? link : sum[11];
  wire [11:0] regBus =
    ctl.shift == SH_RIGHT ? {fillR, sum[11:1]} :
    ctl.shift == SH_LEFT  ? {sum[10:0], fillL} : sum;
  wire shiftOut = ctl.shift == SH_RIGHT ? sum[0] : sum[11];
  wire shiftLink = ctl.shift != SH_PASS && ctl.rotLink;

  wire l1 = ctl.linkClr ? 1'b0 : link;
  wire l2 = ctl.linkCmp ? ~l1 : l1;
  wire l3 = (ctl.linkCarry && carry[12]) ? ~l2 : l2;
  wire next_link = shiftLink ? shiftOut : l3;

  wire loadEn = run || conLdPc || conLdAc;
  wire [2:0] op = ir[11:9];
  wire lastTs = run && tState == TS5;

  // Active registers: captured from the bus on the state-ending edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ac <= `RBD_WORK_RESET;
      pc <= 12'h000;
      ma <= 12'h000;
      mb <= 12'h000;
      ir <= 12'h000;
      link <= 1'b0;
    end else if (loadEn) begin
      if (ctl.ldAc) ac <= regBus;
      if (ctl.ldPc) pc <= regBus;
      if (ctl.ldMa) ma <= regBus;
      if (ctl.ldMb) mb <= regBus;
      if (ctl.ldIr) ir <= regBus;
      link <= next_link;
    end
  end

  // Extension register sits off the bus
  always_ff @(posedge sys_clk) begin
    if (rst) mq <= 12'h000;
    else if (run && ctl.mqFromAc) mq <= ac;
  end

  // Time states; one clock per state while running
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tState <= TS1;
      exec <= 1'b0;
      run <= 1'b0;
      stopReq <= 1'b0;
      conChain <= '0;
    end else begin
      conChain <= {conChain[`RBD_CONSOLE_STEPS-2:0], conStart};
      if (conStop) stopReq <= 1'b1;
      if (conChain[`RBD_CONSOLE_STEPS-1]) begin
        run <= 1'b1;
        tState <= TS1;
        exec <= 1'b0;
        stopReq <= conStop;
      end else if (run) begin
        case (tState)
          TS1: tState <= TS2;
          TS2: tState <= TS3;
          TS3: tState <= TS4;
          TS4: tState <= TS5;
          TS5: begin
            tState <= TS1;
            exec <= !exec && op <= `RBD_OP_DCA;
            if (stopReq || conStop) run <= 1'b0;
          end
          default: tState <= TS1;
        endcase
      end
    end
  end

  // Memory read buffer and I/O transfers on time pulses
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      readBuf <= 12'h000;
      ioBuf <= 12'h000;
      ioOut <= 12'h000;
      ttyTxData <= 8'h00;
      ttyTxStrobe <= 1'b0;
    end else begin
      ttyTxStrobe <= 1'b0;
      if (run && tState == TS2) readBuf <= memRdData;
      if (run && tState == TS3) ioBuf <= ioBus;
      if (run && tState == TS4 && !exec && op == `RBD_OP_IOT) begin
        if (ir[0]) ioOut <= ac;
        if (ir[2]) begin
          ttyTxData <= ac[7:0];
          ttyTxStrobe <= 1'b1;
        end
      end
    end
  end

  // Pin inputs: three stages, accepted once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ioS1 <= 20'h00000;
      ioS2 <= 20'h00000;
      ioS3 <= 20'h00000;
    end else begin
      ioS1 <= {ttyRxData, ioIn};
      ioS2 <= ioS1;
      ioS3 <= ioS2;
    end
  end

  generate
    for (g = 0; g < 20; g = g + 1) begin : gSync
      always_ff @(posedge sys_clk) begin
        if (rst) ioStable[g] <= 1'b0;
        else if (ioS2[g] == ioS3[g]) ioStable[g] <= ioS3[g];
      end
    end
  endgenerate

  // Register readback, captured in the setup cycle
  wire [4:0] stFlags = tState;
  wire mapped = apbReq.paddr <= `RBD_A_IOOUT && apbReq.paddr[1:0] == 2'h0;
  logic [31:0] next_rdData;
  always_comb begin
    case (apbReq.paddr)
      `RBD_A_STATUS: next_rdData = {24'h0, stopReq, exec, run, stFlags};
      `RBD_A_SWITCH: next_rdData = {20'h0, sw};
      `RBD_A_WORK:   next_rdData = {20'h0, ac};
      `RBD_A_LINK:   next_rdData = {31'h0, link};
      `RBD_A_NIP:    next_rdData = {20'h0, pc};
      `RBD_A_MEMLOC: next_rdData = {20'h0, ma};
      `RBD_A_BUFFER: next_rdData = {20'h0, mb};
      `RBD_A_OPCODE: next_rdData = {20'h0, ir};
      `RBD_A_MQEXT:  next_rdData = {20'h0, mq};
      `RBD_A_IOOUT:  next_rdData = {20'h0, ioOut};
      default:       next_rdData = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdData <= 32'h0;
      rdErr <= 1'b0;
      sw <= 12'h000;
    end else begin
      if (apbSetup) begin
        rdData <= next_rdData;
        rdErr <= !mapped;
      end
      if (wrSwitch) sw <= apbReq.pwdata[11:0];
    end
  end

  assign apbRsp = '{prdata: rdData, pready: 1'b1, pslverr: rdErr};
  // Core is destructive; every cycle rewrites the buffer pattern
  assign memOut = '{start: run && tState == TS1,
                    write: run && tState == TS5,
                    addr: ma, wdata: mb};

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_ONEHOT: assert property ($onehot(tState))
    else $error("time state not one-hot");
  AST_CYCLE: assert property (run && tState == TS1 |=> tState == TS2
    ##1 tState == TS3 ##1 tState == TS4 ##1 tState == TS5)
    else $error("time states out of order");
  AST_MEMSTART: assert property (memOut.start |=> !memOut.start [*4])
    else $error("memory start not once per cycle");
  AST_WBACK: assert property (run && tState == TS3 && !exec |=> ##1
    (memOut.write && memOut.wdata == $past(readBuf, 2)
     && memOut.addr == $past(memOut.addr, 2)))
    else $error("fetched word not written back");
  AST_MQ: assert property (!$stable(mq) |-> $past(run && tState == TS5)
    && mq == $past(ac))
    else $error("extension loaded from wrong source");
  AST_LINK: assert property (run && ctl.linkCarry && carry[12]
    |=> link != $past(link))
    else $error("carry did not complement link");
  AST_ADD: assert property (run && exec && tState == TS4 && op == `RBD_OP_TAD
    |=> ac == 12'($past(ac) + $past(mb)))
    else $error("sum not in work register");
  AST_PCINC: assert property (run && tState == TS2 && !exec
    |=> pc == 12'($past(pc) + 12'h001))
    else $error("pointer not advanced");
  AST_START: assert property ($rose(run) |-> tState == TS1
    && $past(conChain[`RBD_CONSOLE_STEPS-1]))
    else $error("timing started without console chain");
  AST_IRLOAD: assert property (!$stable(ir) |-> $past(tState == TS3 && !exec))
    else $error("opcode register loaded outside fetch");

  COV_TAD: cover property (run && exec && tState == TS4 && op == `RBD_OP_TAD);
  COV_CARRY: cover property (run && ctl.linkCarry && carry[12]);
  COV_STOP: cover property ($fell(run));
endmodule // rbd_register_bus_datapath

// *** rtl/rbd_defines.svh ***
/*
  Register offsets, control bit positions, opcodes and timing counts for
  the register bus datapath. Assumes a byte-addressed APB with 8-bit paddr.
*/
`ifndef RBD_DEFINES_SVH
`define RBD_DEFINES_SVH

`define RBD_A_CTRL    8'h00
`define RBD_A_STATUS  8'h04
`define RBD_A_SWITCH  8'h08
`define RBD_A_WORK    8'h0c
`define RBD_A_LINK    8'h10
`define RBD_A_NIP     8'h14
`define RBD_A_MEMLOC  8'h18
`define RBD_A_BUFFER  8'h1c
`define RBD_A_OPCODE  8'h20
`define RBD_A_MQEXT   8'h24
`define RBD_A_IOOUT   8'h28

`define RBD_CTRL_START 0
`define RBD_CTRL_STOP  1
`define RBD_CTRL_LDNIP 2
`define RBD_CTRL_LDWRK 3

`define RBD_OP_AND 3'h0
`define RBD_OP_TAD 3'h1
`define RBD_OP_CMP 3'h2
`define RBD_OP_DCA 3'h3
`define RBD_OP_JMP 3'h4
`define RBD_OP_IOT 3'h5
`define RBD_OP_MQL 3'h6
`define RBD_OP_OPR 3'h7

`define RBD_CONSOLE_STEPS 3
`define RBD_WORK_RESET    12'h000

`endif

// *** rtl/rbd_pkg.sv ***
/*
  Types of the register bus datapath: time states, shift modes, the
  decoded control word and the bus and memory carriers.
  Assumes nothing of its surroundings.
*/
package rbd_pkg;
  typedef enum logic [4:0] {
    TS1 = 5'b00001,
    TS2 = 5'b00010,
    TS3 = 5'b00100,
    TS4 = 5'b01000,
    TS5 = 5'b10000
  } rbd_tstate_t;

  typedef enum logic [1:0] {
    SH_PASS  = 2'h0,
    SH_RIGHT = 2'h1,
    SH_LEFT  = 2'h2
  } rbd_shift_t;

  typedef struct packed {
    logic enAc, enAcN, enPc, enMb, enRd, enIo, enSw, enAddr, enAnd;
    logic carryIn;
    rbd_shift_t shift;
    logic rotLink;
    logic ldAc, ldPc, ldMa, ldMb, ldIr, mqFromAc;
    logic linkClr, linkCmp, linkCarry;
  } rbd_ctl_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } rbd_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } rbd_apb_rsp_t;

  typedef struct packed {
    logic        start;
    logic        write;
    logic [11:0] addr;
    logic [11:0] wdata;
  } rbd_mem_t;
endpackage

// *** bench/rbd_core_mem_model.sv ***
/*
  Core memory control partner: a word array that answers a read only in
  the state after start, and takes the write pattern while write is high.
  Assumes the datapath pulses start in TS1 and write in TS5.
*/
`timescale 1ns/1ps
module rbd_core_mem_model (
  // Clock
  input  wire logic              sys_clk,
  // Datapath side
  input  wire rbd_pkg::rbd_mem_t memOut,
  output      logic [11:0]       memRdData
);
  import rbd_pkg::*;
  logic [11:0] mem [0:4095];
  logic        readWin;
  logic [11:0] lastRd;
  // Outside the one-state read window the line shows the inverse of its last word
  assign memRdData = readWin ? mem[memOut.addr] : ~lastRd;
  always @(posedge sys_clk) begin
    readWin <= memOut.start;
    if (readWin) begin
      lastRd <= memRdData;
    end
    if (memOut.write) begin
      mem[memOut.addr] <= memOut.wdata;
    end
  end
endmodule // rbd_core_mem_model

// *** bench/register_bus_datapath_tb_top.sv ***
/*
  Self-checking bench: APB register access, console loads and a short
  program run against the core memory model.
  Assumes an APB slave on sys_clk and one-cycle time states.
*/
`timescale 1ns/1ps
`include "rbd_defines.svh"
module register_bus_datapath_tb_top;
  import rbd_pkg::*;
  localparam logic [23:0] PROG [14] = '{24'h010240, 24'h011e01, 24'h012a05, 24'h013c00,
    24'h014a02, 24'h015e20, 24'h016442, 24'h017e80, 24'h018e06, 24'h019641,
    24'h01a81a, 24'h0400ff, 24'h042cf3, 24'h041000};
  logic         sys_clk = 1'b0;
  logic         rst = 1'b1;
  rbd_apb_req_t apbReq = '0;
  rbd_apb_rsp_t apbRsp;
  rbd_mem_t     memOut;
  logic [11:0]  memRdData;
  logic [11:0]  ioIn = 12'h300;
  logic [7:0]   ttyRxData = 8'h0c;
  logic [11:0]  ioOut;
  logic [7:0]   ttyTxData;
  logic         ttyTxStrobe;
  logic [7:0]   txData;
  logic [31:0]  rdata;
  logic         err;
  int           num_errors = 0;
  int           comparisons = 0;
  int           cyc = 0;
  int           lastStart = -1;
  int           txCount = 0;

  always #2.5 sys_clk = ~sys_clk;

  rbd_register_bus_datapath u_dut (.sys_clk(sys_clk), .rst(rst), .apbReq(apbReq),
    .apbRsp(apbRsp), .memOut(memOut), .memRdData(memRdData), .ioIn(ioIn),
    .ttyRxData(ttyRxData), .ioOut(ioOut), .ttyTxData(ttyTxData), .ttyTxStrobe(ttyTxStrobe));
  rbd_core_mem_model u_mem (.sys_clk(sys_clk), .memOut(memOut), .memRdData(memRdData));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Request held from setup until pready is sampled high at an access edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    apbReq <= '{1'b1, 1'b0, wr, a, d};
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (apbRsp.pready !== 1'b1);
    rdata = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rdata, exp);
  endtask

  // Polls over the bus, so the wait is bounded in transfers rather than fixed cycles
  task automatic poll(input string what, input logic [7:0] a, input logic [31:0] mask,
                      input logic [31:0] val);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((rdata & mask) !== val && n < 200);
    check(what, rdata & mask, val);
  endtask

  // Sampled mid-cycle, where the combinational strobes have settled
  always @(negedge sys_clk) begin
    cyc++;
    if (memOut.start === 1'b1) begin
      if (lastStart >= 0) check("cycle length", cyc - lastStart, 5);
      lastStart = cyc;
    end
    if (memOut.write === 1'b1) check("start to write", cyc - lastStart, 4);
    if (ttyTxStrobe === 1'b1) begin
      txCount++;
      txData = ttyTxData;
    end
  end

  task automatic t_reset;
    rd_chk("status", `RBD_A_STATUS, 32'h01);
    rd_chk("work", `RBD_A_WORK, 32'h0);
    rd_chk("pointer", `RBD_A_NIP, 32'h0);
    apb(1'b0, 8'h2c, 32'h0);
    check("unmapped err", err, 32'h1);
    apb(1'b1, `RBD_A_WORK, 32'habc);
    rd_chk("work read only", `RBD_A_WORK, 32'h0);
  endtask

  task automatic t_console;
    apb(1'b1, `RBD_A_SWITCH, 32'h010);
    apb(1'b1, `RBD_A_CTRL, 32'h1 << `RBD_CTRL_LDNIP);
    apb(1'b1, `RBD_A_SWITCH, 32'hf01);
    apb(1'b1, `RBD_A_CTRL, 32'h1 << `RBD_CTRL_LDWRK);
    rd_chk("switch", `RBD_A_SWITCH, 32'hf01);
    rd_chk("ctrl", `RBD_A_CTRL, 32'h0);
    rd_chk("pointer load", `RBD_A_NIP, 32'h010);
    rd_chk("work load", `RBD_A_WORK, 32'hf01);
  endtask

  // Add with carry, increment, output, move, input, complement, skip, rotate, store, loop
  task automatic t_program;
    apb(1'b1, `RBD_A_CTRL, 32'h1 << `RBD_CTRL_START);
    poll("running", `RBD_A_STATUS, 32'h20, 32'h20);
    poll("loop fetched", `RBD_A_OPCODE, 32'hfff, 32'h81a);
    apb(1'b1, `RBD_A_SWITCH, 32'h555);
    apb(1'b1, `RBD_A_CTRL, 32'h1 << `RBD_CTRL_LDWRK);
    apb(1'b1, `RBD_A_CTRL, 32'h1 << `RBD_CTRL_STOP);
    poll("stopped", `RBD_A_STATUS, 32'h20, 32'h0);
    rd_chk("work after store", `RBD_A_WORK, 32'h0);
    rd_chk("link", `RBD_A_LINK, 32'h1);
    rd_chk("extension", `RBD_A_MQEXT, 32'h001);
    rd_chk("io out", `RBD_A_IOOUT, 32'h001);
    rd_chk("pointer jump", `RBD_A_NIP, 32'h01a);
    check("io pins", ioOut, 32'h001);
    check("tty count", txCount, 32'h1);
    check("tty data", txData, 32'h01);
    check("rotated store", u_mem.mem[12'h041], 32'h9e7);
    check("writeback", u_mem.mem[12'h010], 32'h240);
    check("skip target", u_mem.mem[12'h017], 32'he80);
  endtask

  initial begin
    for (int i = 0; i < 4096; i++) begin
      u_mem.mem[i] = 12'h000;
    end
    for (int i = 0; i < 14; i++) begin
      u_mem.mem[PROG[i][23:12]] = PROG[i][11:0];
    end
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_console();
    t_program();
    report_and_stop();
  end

  initial begin
    repeat (40000) @(posedge sys_clk);
    num_errors++;
    report_and_stop();
  end
endmodule // register_bus_datapath_tb_top
